/* File: hdl/rph_pkg.sv */
// Shared constants and types for the receive packet handler
package rph_pkg;
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [1:0] LEN_VARIABLE = 2'h1;
    localparam logic [1:0] LEN_UNBOUNDED = 2'h2;
    localparam logic [1:0] ADR_OFF = 2'h0;
    localparam logic [1:0] ADR_BCAST0 = 2'h2;
    localparam logic [1:0] ADR_BCAST_BOTH = 2'h3;
    localparam logic [7:0] BCAST_ZERO = 8'h00;
    localparam logic [7:0] BCAST_ONES = 8'hFF;
    localparam logic [7:0] UNBOUNDED_MARK = 8'hFF;
    localparam logic [2:0] SQ_NONE = 3'h0;
    localparam logic [2:0] SQ_NONE_CS = 3'h4;
    localparam logic [1:0] SQ_MATCH15 = 2'h1;
    localparam logic [1:0] SQ_MATCH16 = 2'h2;
    localparam logic [1:0] SQ_MATCH30 = 2'h3;
    localparam int SQ_CS_BIT = 2;
    localparam logic [5:0] HITS_15 = 6'h0F;
    localparam logic [5:0] HITS_16 = 6'h10;
    localparam logic [5:0] HITS_30 = 6'h1E;
    localparam logic [5:0] PIN_FIFO_THR = 6'h00;
    localparam logic [5:0] PIN_FIFO_THR_END = 6'h01;
    localparam logic [5:0] PIN_SYNC_PKT = 6'h06;
    localparam logic [1:0] POST_RX = 2'h3;
    localparam int STAT_OK_BIT = 7;
    localparam logic [6:0] STAT_RSVD = 7'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    typedef enum logic [3:0] {
        RPH_IDLE = 4'h0,
        RPH_SYNC = 4'h1,
        RPH_LEN = 4'h3,
        RPH_ADDR = 4'h2,
        RPH_DATA = 4'h6,
        RPH_CRC_HI = 4'h7,
        RPH_CRC_LO = 4'h5,
        RPH_STAT1 = 4'h4,
        RPH_STAT2 = 4'hC,
        RPH_END = 4'hD
    } rph_state_e;
endpackage

/* File: hdl/rph_crc16.sv */
// Byte-serial 16-bit checksum accumulator
`timescale 1ns/100ps
`default_nettype none
module rph_crc16 #(
    parameter logic [15:0] POLY = rph_pkg::CRC_POLY,
    parameter logic [15:0] INIT = rph_pkg::CRC_INIT
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [15:0] crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    // MSB-first shift of one byte through the polynomial
    always_comb begin
        crc_nxt = crc_r;
        for (int i = 7; i >= 0; i--) begin
            if (crc_nxt[15] ^ data[i]) begin
                crc_nxt = {crc_nxt[14:0], 1'b0} ^ POLY;
            end else begin
                crc_nxt = {crc_nxt[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crc_r <= rph_pkg::CRC_INIT;
        end else if (clr) begin
            crc_r <= INIT;
        end else if (en) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule
`default_nettype wire

/* File: hdl/rph_rx_packet.sv */
// Receive packet handler: sync search, delineation, filtering, FIFO and status pin
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - First trailer byte carries signal strength
// - Second trailer byte bit7 checksum ok
// - Expect sync, length, address, payload, checksum
// - Modes 3 and 7 search doubled sync word
// - Fixed mode receives programmed length bytes
// - Variable mode takes first byte as length
// - Oversized length byte discards and restarts
// - Unbounded mode runs until host stops
// - Packet ends when counter equals live length
// - Byte counter wraps from 255 to 0, with no packet end
// - Address filter with optional broadcast addresses
// - Address mismatch discards packet and restarts
// - Unbounded filtered packet stores 0xFF, address, payload
// - Checksum failure with auto-flush empties FIFO
// - Store length byte or accept programmed count
// - Pin code 0x06 flags sync and packet end
// - Pin codes 0x00, 0x01 show FIFO fill
// - Trailer uses last strength value of packet
// - Sync word correlated most significant bit first
module rph_rx_packet #(
    parameter int FIFO_DEPTH = 64,
    parameter int FIFO_AW = 6,
    parameter logic [FIFO_AW:0] FIFO_THRESHOLD = 7'h20
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rx_enable,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic carrier_sense,
    input wire logic [7:0] rssi_value,
    input wire logic [7:0] sync_word_high_byte,
    input wire logic [7:0] sync_word_low_byte,
    input wire logic [2:0] sync_qualifier_mode,
    input wire logic [1:0] length_mode_select,
    input wire logic [7:0] packet_length_value,
    input wire logic [1:0] address_check_setting,
    input wire logic [7:0] node_address,
    input wire logic checksum_enable,
    input wire logic checksum_fail_empty_enable,
    input wire logic trailer_status_enable,
    input wire logic [1:0] post_receive_state_select,
    input wire logic [5:0] output_pin_function_code,
    input wire logic fifo_read,
    output logic [7:0] fifo_rd_data,
    output logic [FIFO_AW:0] fifo_level,
    output logic fifo_overflow,
    output logic general_output_pin,
    output logic rx_idle,
    output logic sync_found,
    output logic packet_done,
    output logic checksum_ok
);
    rph_pkg::rph_state_e state_r;
    rph_pkg::rph_state_e state_nxt;
    logic [31:0] sync_sr_r;
    logic [31:0] sync_sr_nxt;
    logic [7:0] byte_sr_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] byte_val;
    logic byte_stb;
    logic [7:0] byte_cnt_r;
    logic [7:0] length_r;
    logic [15:0] rx_crc_r;
    logic [7:0] rssi_last_r;
    logic addr_hold_r;
    logic [7:0] addr_byte_r;
    logic [7:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_r;
    logic [FIFO_AW-1:0] rd_ptr_r;
    logic [FIFO_AW-1:0] start_ptr_r;
    logic [FIFO_AW:0] count_r;
    logic [FIFO_AW:0] pkt_wr_r;
    logic wr_en;
    logic [7:0] wr_data;
    logic wr_ok;
    logic rd_ok;
    logic sync_hit;
    logic len_bad;
    logic addr_bad;
    logic discard;
    logic end_hit;
    logic crc_match;
    logic flush;
    logic crc_clr;
    logic crc_en;
    logic [15:0] crc_calc;
    logic pin_r;
    logic [7:0] rd_data_r;
    logic ovf_r;
    logic idle_r;
    logic sync_pulse_r;
    logic done_r;
    logic ok_r;

    function automatic logic [5:0] ones32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction

    function automatic logic addr_pass(input logic [1:0] sel, input logic [7:0] a,
                                       input logic [7:0] node);
        addr_pass = (a == node) ||
            ((sel == rph_pkg::ADR_BCAST0) && (a == rph_pkg::BCAST_ZERO)) ||
            ((sel == rph_pkg::ADR_BCAST_BOTH) &&
             ((a == rph_pkg::BCAST_ZERO) || (a == rph_pkg::BCAST_ONES)));
    endfunction

    assign byte_val = {byte_sr_r[6:0], rx_bit};
    assign byte_stb = rx_bit_valid && (bit_cnt_r == rph_pkg::LAST_BIT) &&
        (state_r != rph_pkg::RPH_IDLE) && (state_r != rph_pkg::RPH_SYNC) &&
        (state_r != rph_pkg::RPH_STAT1) && (state_r != rph_pkg::RPH_STAT2) &&
        (state_r != rph_pkg::RPH_END);
    assign sync_sr_nxt = {sync_sr_r[30:0], rx_bit};

    // Sync qualification
    always_comb begin
        logic [15:0] word;
        logic cs_ok;
        word = {sync_word_high_byte, sync_word_low_byte};
        cs_ok = !sync_qualifier_mode[rph_pkg::SQ_CS_BIT] || carrier_sense;
        case (sync_qualifier_mode[1:0])
            rph_pkg::SQ_MATCH15: begin
                sync_hit = rx_bit_valid && cs_ok &&
                    (ones32({16'h0000, ~(sync_sr_nxt[15:0] ^ word)}) >= rph_pkg::HITS_15);
            end
            rph_pkg::SQ_MATCH16: begin
                sync_hit = rx_bit_valid && cs_ok &&
                    (ones32({16'h0000, ~(sync_sr_nxt[15:0] ^ word)}) >= rph_pkg::HITS_16);
            end
            rph_pkg::SQ_MATCH30: begin
                sync_hit = rx_bit_valid && cs_ok &&
                    (ones32(~(sync_sr_nxt ^ {word, word})) >= rph_pkg::HITS_30);
            end
            default: begin
                sync_hit = cs_ok;
            end
        endcase
    end

    assign len_bad = (state_r == rph_pkg::RPH_LEN) && byte_stb &&
        (byte_val > packet_length_value);
    assign addr_bad = (state_r == rph_pkg::RPH_ADDR) && byte_stb &&
        !addr_pass(address_check_setting, byte_val, node_address);
    assign discard = len_bad || addr_bad;
    always_comb begin
        case (length_mode_select)
            rph_pkg::LEN_FIXED: end_hit = (byte_cnt_r == packet_length_value);
            rph_pkg::LEN_VARIABLE: end_hit = (byte_cnt_r == length_r);
            default: end_hit = 1'b0;
        endcase
    end
    assign crc_match = ({rx_crc_r[15:8], byte_val} == crc_calc);
    assign flush = (state_r == rph_pkg::RPH_CRC_LO) && byte_stb &&
        checksum_fail_empty_enable && !crc_match;

    // Packet sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rph_pkg::RPH_IDLE: begin
                if (rx_enable) state_nxt = rph_pkg::RPH_SYNC;
            end
            rph_pkg::RPH_SYNC: begin
                if (sync_hit) begin
                    if (length_mode_select == rph_pkg::LEN_VARIABLE) begin
                        state_nxt = rph_pkg::RPH_LEN;
                    end else if (address_check_setting != rph_pkg::ADR_OFF) begin
                        state_nxt = rph_pkg::RPH_ADDR;
                    end else begin
                        state_nxt = rph_pkg::RPH_DATA;
                    end
                end
            end
            rph_pkg::RPH_LEN: begin
                if (len_bad) begin
                    state_nxt = rph_pkg::RPH_SYNC;
                end else if (byte_stb) begin
                    state_nxt = (address_check_setting != rph_pkg::ADR_OFF) ?
                        rph_pkg::RPH_ADDR : rph_pkg::RPH_DATA;
                end
            end
            rph_pkg::RPH_ADDR: begin
                if (addr_bad) begin
                    state_nxt = rph_pkg::RPH_SYNC;
                end else if (byte_stb) begin
                    state_nxt = rph_pkg::RPH_DATA;
                end
            end
            rph_pkg::RPH_DATA: begin
                if (end_hit && !addr_hold_r) begin
                    if (checksum_enable) begin
                        state_nxt = rph_pkg::RPH_CRC_HI;
                    end else begin
                        state_nxt = trailer_status_enable ? rph_pkg::RPH_STAT1 :
                            rph_pkg::RPH_END;
                    end
                end
            end
            rph_pkg::RPH_CRC_HI: begin
                if (byte_stb) state_nxt = rph_pkg::RPH_CRC_LO;
            end
            rph_pkg::RPH_CRC_LO: begin
                if (flush) begin
                    state_nxt = rph_pkg::RPH_END;
                end else if (byte_stb) begin
                    state_nxt = trailer_status_enable ? rph_pkg::RPH_STAT1 :
                        rph_pkg::RPH_END;
                end
            end
            rph_pkg::RPH_STAT1: state_nxt = rph_pkg::RPH_STAT2;
            rph_pkg::RPH_STAT2: state_nxt = rph_pkg::RPH_END;
            rph_pkg::RPH_END: begin
                state_nxt = (post_receive_state_select == rph_pkg::POST_RX) ?
                    rph_pkg::RPH_SYNC : rph_pkg::RPH_IDLE;
            end
            default: state_nxt = rph_pkg::RPH_IDLE;
        endcase
        if (!rx_enable) state_nxt = rph_pkg::RPH_IDLE;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= rph_pkg::RPH_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit shifting and byte framing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_sr_r <= 32'h0000_0000;
            byte_sr_r <= 8'h00;
            bit_cnt_r <= 3'h0;
        end else if (state_r == rph_pkg::RPH_SYNC || state_r == rph_pkg::RPH_IDLE) begin
            bit_cnt_r <= 3'h0;
            if (rx_bit_valid) sync_sr_r <= sync_sr_nxt;
        end else if (rx_bit_valid) begin
            byte_sr_r <= byte_val;
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    // Packet counters and captured fields
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            byte_cnt_r <= 8'h00;
            length_r <= 8'h00;
            rx_crc_r <= 16'h0000;
            rssi_last_r <= 8'h00;
            addr_hold_r <= 1'b0;
            addr_byte_r <= 8'h00;
        end else begin
            if (state_r == rph_pkg::RPH_SYNC) byte_cnt_r <= 8'h00;
            else if (state_r == rph_pkg::RPH_DATA && byte_stb) byte_cnt_r <= byte_cnt_r + 8'h01;
            if (state_r == rph_pkg::RPH_LEN && byte_stb) length_r <= byte_val;
            if (state_r == rph_pkg::RPH_CRC_HI && byte_stb) rx_crc_r[15:8] <= byte_val;
            if (state_r == rph_pkg::RPH_CRC_LO && byte_stb) rx_crc_r[7:0] <= byte_val;
            if (byte_stb) rssi_last_r <= rssi_value;
            addr_hold_r <= (state_r == rph_pkg::RPH_ADDR) && byte_stb && !addr_bad &&
                (length_mode_select == rph_pkg::LEN_UNBOUNDED);
            if (state_r == rph_pkg::RPH_ADDR && byte_stb) addr_byte_r <= byte_val;
        end
    end

    assign crc_clr = (state_r == rph_pkg::RPH_SYNC);
    assign crc_en = byte_stb && ((state_r == rph_pkg::RPH_LEN) ||
        (state_r == rph_pkg::RPH_ADDR) || (state_r == rph_pkg::RPH_DATA));

    rph_crc16 u_crc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clr(crc_clr),
        .en(crc_en),
        .data(byte_val),
        .crc(crc_calc)
    );

    // FIFO write source selection
    always_comb begin
        wr_en = 1'b0;
        wr_data = byte_val;
        if (addr_hold_r) begin
            wr_en = 1'b1;
            wr_data = addr_byte_r;
        end else begin
            case (state_r)
                rph_pkg::RPH_LEN: wr_en = byte_stb && !len_bad;
                rph_pkg::RPH_ADDR: begin
                    wr_en = byte_stb && !addr_bad;
                    if (length_mode_select == rph_pkg::LEN_UNBOUNDED) begin
                        wr_data = rph_pkg::UNBOUNDED_MARK;
                    end
                end
                rph_pkg::RPH_DATA: wr_en = byte_stb;
                rph_pkg::RPH_STAT1: begin
                    wr_en = 1'b1;
                    wr_data = rssi_last_r;
                end
                rph_pkg::RPH_STAT2: begin
                    wr_en = 1'b1;
                    wr_data = {ok_r, rph_pkg::STAT_RSVD};
                end
                default: wr_en = 1'b0;
            endcase
        end
    end

    assign wr_ok = wr_en && (count_r != FIFO_DEPTH[FIFO_AW:0]);
    assign rd_ok = fifo_read && (count_r != '0);

    // Receive FIFO storage and pointers
    always_ff @(posedge clk_sys) begin
        if (wr_ok) mem[wr_ptr_r] <= wr_data;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            start_ptr_r <= '0;
            count_r <= '0;
            pkt_wr_r <= '0;
            rd_data_r <= 8'h00;
            ovf_r <= 1'b0;
        end else begin
            if (rd_ok) rd_data_r <= mem[rd_ptr_r];
            if (wr_en && !wr_ok) ovf_r <= 1'b1;
            else if (state_r == rph_pkg::RPH_IDLE) ovf_r <= 1'b0;
            if (flush) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                count_r <= '0;
                pkt_wr_r <= '0;
            end else if (discard) begin
                // Roll back bytes already stored for the rejected packet
                wr_ptr_r <= start_ptr_r;
                if (rd_ok) rd_ptr_r <= rd_ptr_r + 1'b1;
                if (pkt_wr_r + {{FIFO_AW{1'b0}}, rd_ok} >= count_r) count_r <= '0;
                else count_r <= count_r - pkt_wr_r - {{FIFO_AW{1'b0}}, rd_ok};
                pkt_wr_r <= '0;
            end else begin
                if (wr_ok) wr_ptr_r <= wr_ptr_r + 1'b1;
                if (rd_ok) rd_ptr_r <= rd_ptr_r + 1'b1;
                count_r <= count_r + {{FIFO_AW{1'b0}}, wr_ok} - {{FIFO_AW{1'b0}}, rd_ok};
                if (state_r == rph_pkg::RPH_SYNC) begin
                    start_ptr_r <= wr_ptr_r;
                    pkt_wr_r <= '0;
                end else if (wr_ok) begin
                    pkt_wr_r <= pkt_wr_r + 1'b1;
                end
            end
        end
    end

    // Status flags and output pin
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idle_r <= 1'b1;
            sync_pulse_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b1;
            pin_r <= 1'b0;
        end else begin
            idle_r <= (state_nxt == rph_pkg::RPH_IDLE);
            sync_pulse_r <= (state_r == rph_pkg::RPH_SYNC) && (state_nxt != rph_pkg::RPH_SYNC) &&
                rx_enable;
            done_r <= (state_r == rph_pkg::RPH_END);
            if (state_r == rph_pkg::RPH_SYNC) ok_r <= 1'b1;
            else if (state_r == rph_pkg::RPH_CRC_LO && byte_stb) ok_r <= crc_match;
            case (output_pin_function_code)
                rph_pkg::PIN_FIFO_THR: pin_r <= (count_r >= FIFO_THRESHOLD);
                rph_pkg::PIN_FIFO_THR_END: begin
                    if (count_r >= FIFO_THRESHOLD || state_r == rph_pkg::RPH_END) pin_r <= 1'b1;
                    else if (count_r == '0) pin_r <= 1'b0;
                end
                rph_pkg::PIN_SYNC_PKT: begin
                    if (state_r == rph_pkg::RPH_SYNC && state_nxt != rph_pkg::RPH_SYNC &&
                        state_nxt != rph_pkg::RPH_IDLE) pin_r <= 1'b1;
                    else if (state_r == rph_pkg::RPH_END || discard ||
                        state_r == rph_pkg::RPH_IDLE) pin_r <= 1'b0;
                end
                default: pin_r <= 1'b0;
            endcase
        end
    end

    assign fifo_rd_data = rd_data_r;
    assign fifo_level = count_r;
    assign fifo_overflow = ovf_r;
    assign general_output_pin = pin_r;
    assign rx_idle = idle_r;
    assign sync_found = sync_pulse_r;
    assign packet_done = done_r;
    assign checksum_ok = ok_r;
endmodule
`default_nettype wire

/* File: verif/rph_rx_props.sv */
// Port checker for the receive packet handler
`timescale 1ns/100ps
`default_nettype none
module rph_rx_props #(
    parameter int FIFO_AW = 6
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rx_enable,
    input wire logic checksum_enable,
    input wire logic checksum_fail_empty_enable,
    input wire logic [5:0] output_pin_function_code,
    input wire logic fifo_read,
    input wire logic [FIFO_AW:0] fifo_level,
    input wire logic general_output_pin,
    input wire logic rx_idle,
    input wire logic sync_found,
    input wire logic packet_done,
    input wire logic checksum_ok
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_sync_pulse;
        sync_found |=> !sync_found;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
    property p_done_pulse;
        packet_done |=> !packet_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
    property p_pin_sync;
        output_pin_function_code == rph_pkg::PIN_SYNC_PKT && $rose(sync_found)
            |-> ##[0:1] general_output_pin;
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin missed sync");
    property p_pin_level;
        (output_pin_function_code == rph_pkg::PIN_FIFO_THR && fifo_level < 7'h1F) [*2]
            |-> !general_output_pin;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin high below fill mark");
    property p_stop;
        !rx_enable [*2] |-> rx_idle;
    endproperty
    a_stop: assert property (p_stop) else $error("not idle after stop");
    property p_flush;
        checksum_fail_empty_enable && $fell(checksum_ok) |-> ##[0:2] fifo_level == 7'h00;
    endproperty
    a_flush: assert property (p_flush) else $error("FIFO not emptied");
    property p_ok_off;
        packet_done && !checksum_enable |-> checksum_ok;
    endproperty
    a_ok_off: assert property (p_ok_off) else $error("status bad with check off");
    property p_idle_quiet;
        rx_idle [*2] ##0 !fifo_read |=> $stable(fifo_level);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("FIFO written while idle");
endmodule
bind rph_rx_packet rph_rx_props #(.FIFO_AW(FIFO_AW)) u_props (.clk_sys(clk_sys),
    .nrst(nrst), .rx_enable(rx_enable), .checksum_enable(checksum_enable),
    .checksum_fail_empty_enable(checksum_fail_empty_enable),
    .output_pin_function_code(output_pin_function_code), .fifo_read(fifo_read),
    .fifo_level(fifo_level), .general_output_pin(general_output_pin), .rx_idle(rx_idle),
    .sync_found(sync_found), .packet_done(packet_done), .checksum_ok(checksum_ok));
`default_nettype wire

/* File: verif/rph_host_model.sv */
// Host model that pops bytes from the receive FIFO
`timescale 1ns/100ps
`default_nettype none
module rph_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] fifo_rd_data,
    input wire logic [6:0] fifo_level,
    output logic fifo_read
);
    initial fifo_read = 1'b0;
    // One pop; the byte is valid the cycle after the request
    task automatic pop(output logic [7:0] v);
        @(posedge clk_sys);
        fifo_read <= 1'b1;
        @(posedge clk_sys);
        fifo_read <= 1'b0;
        #1 v = fifo_rd_data;
    endtask
    // Empty the previous packet before the next one arrives
    task automatic drain();
        logic [7:0] v;
        while (fifo_level != 7'h00) pop(v);
    endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the receive packet handler
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys, nrst, rx_enable, rx_bit, rx_bit_valid, checksum_enable, flush_en;
    logic trailer_en, fifo_read, general_output_pin, rx_idle, sync_found, packet_done, checksum_ok;
    logic [7:0] rssi_value, packet_length_value, node_address, fifo_rd_data;
    logic [6:0] fifo_level;
    logic [5:0] pin_code;
    logic [2:0] sq;
    logic [1:0] len_mode, adr_chk;
    int failures = 0, n_tests = 0, n_done = 0;
    rph_rx_packet uut (.clk_sys, .nrst, .rx_enable, .rx_bit, .rx_bit_valid,
        .carrier_sense(1'b0), .rssi_value, .sync_word_high_byte(8'hD3),
        .sync_word_low_byte(8'h91), .sync_qualifier_mode(sq), .length_mode_select(len_mode),
        .packet_length_value, .address_check_setting(adr_chk), .node_address,
        .checksum_enable, .checksum_fail_empty_enable(flush_en),
        .trailer_status_enable(trailer_en), .post_receive_state_select(2'h0),
        .output_pin_function_code(pin_code), .fifo_read, .fifo_rd_data, .fifo_level,
        .fifo_overflow(), .general_output_pin, .rx_idle, .sync_found, .packet_done,
        .checksum_ok);
    rph_host_model host (.clk_sys, .fifo_rd_data, .fifo_level, .fifo_read);
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (packet_done === 1'b1) n_done++;
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // Bits are spaced four clocks apart, most significant first
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            rx_bit <= v[i];
            rx_bit_valid <= 1'b1;
            @(posedge clk_sys);
            rx_bit_valid <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task automatic frame();
        send(8'hAA);
        send(8'hAA);
        repeat ((sq == 3'h3) ? 2 : 1) begin
            send(8'hD3);
            send(8'h91);
        end
    endtask
    // Configuration is only touched with the receiver stopped
    task automatic cfg(input logic [1:0] lm, input logic [7:0] pl, input logic [1:0] ad,
                       input logic ck, input logic [5:0] pc, input logic [2:0] s);
        @(posedge clk_sys);
        rx_enable <= 1'b0;
        len_mode <= lm;
        packet_length_value <= pl;
        adr_chk <= ad;
        checksum_enable <= ck;
        flush_en <= ck;
        pin_code <= pc;
        sq <= s;
        repeat (3) @(posedge clk_sys);
        rx_enable <= 1'b1;
    endtask
    task automatic wait_done(input logic want);
        int k;
        k = n_done;
        for (int i = 0; i < 300 && n_done == k; i++) @(posedge clk_sys);
        chk({7'h0, n_done != k}, {7'h0, want}, "packet end");
    endtask
    task automatic expect_fifo(input logic [31:0] w, input int n);
        logic [7:0] v;
        chk({1'b0, fifo_level}, 8'(n), "fill level");
        for (int i = 0; i < n; i++) begin
            host.pop(v);
            chk(v, w[8*(n-1-i)+:8], "fifo byte");
        end
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ rph_pkg::CRC_POLY : {c[14:0], 1'b0};
        return c;
    endfunction
    task automatic t_fixed();
        cfg(rph_pkg::LEN_FIXED, 8'h02, rph_pkg::ADR_OFF, 1'b0, rph_pkg::PIN_SYNC_PKT, 3'h2);
        frame();
        chk({7'h0, general_output_pin}, 8'h01, "pin on sync");
        send(8'h3C);
        send(8'hC3);
        wait_done(1'b1);
        repeat (2) @(posedge clk_sys);
        chk({7'h0, general_output_pin}, 8'h00, "pin after end");
        expect_fifo(32'h3CC3_5A80, 4);
    endtask
    task automatic t_variable();
        cfg(rph_pkg::LEN_VARIABLE, 8'h02, rph_pkg::ADR_OFF, 1'b0, 6'h00, 3'h3);
        frame();
        send(8'h03);
        repeat (8) @(posedge clk_sys);
        chk({1'b0, fifo_level}, 8'h00, "oversize dropped");
        frame();
        send(8'h01);
        send(8'h7E);
        wait_done(1'b1);
        expect_fifo(32'h017E_5A80, 4);
    endtask
    task automatic t_address();
        cfg(rph_pkg::LEN_FIXED, 8'h01, rph_pkg::ADR_BCAST0, 1'b0, 6'h00, 3'h2);
        frame();
        send(8'h55);
        repeat (8) @(posedge clk_sys);
        chk({1'b0, fifo_level}, 8'h00, "mismatch dropped");
        frame();
        send(8'h00);
        send(8'h99);
        wait_done(1'b1);
        expect_fifo(32'h0099_5A80, 4);
        cfg(rph_pkg::LEN_UNBOUNDED, 8'h01, rph_pkg::ADR_BCAST_BOTH, 1'b0, 6'h00, 3'h2);
        frame();
        send(8'hFF);
        send(8'h11);
        repeat (4) @(posedge clk_sys);
        expect_fifo(32'h00FF_FF11, 3);
    endtask
    task automatic t_checksum();
        logic [15:0] c;
        c = crc(crc(rph_pkg::CRC_INIT, 8'hA5), 8'h5A);
        rssi_value <= 8'h6C;
        cfg(rph_pkg::LEN_FIXED, 8'h02, rph_pkg::ADR_OFF, 1'b1, rph_pkg::PIN_FIFO_THR_END, 3'h2);
        for (int p = 0; p < 2; p++) begin
            frame();
            send(8'hA5);
            send(8'h5A);
            send(c[15:8]);
            send(c[7:0] ^ 8'(p));
            wait_done(1'b1);
            chk({7'h0, checksum_ok}, 8'(p == 0), "checksum status");
            repeat (2) @(posedge clk_sys);
            if (p == 0) begin
                chk({7'h0, general_output_pin}, 8'h01, "pin at end");
                expect_fifo(32'hA55A_6C80, 4);
                repeat (2) @(posedge clk_sys);
                chk({7'h0, general_output_pin}, 8'h00, "pin when empty");
                host.drain();
                cfg(rph_pkg::LEN_FIXED, 8'h02, rph_pkg::ADR_OFF, 1'b1, 6'h01, 3'h2);
            end else chk({1'b0, fifo_level}, 8'h00, "flushed");
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {nrst, rx_enable, rx_bit, rx_bit_valid, checksum_enable, flush_en} = '0;
        {packet_length_value, node_address, pin_code, sq, len_mode, adr_chk} = '0;
        trailer_en = 1'b1;
        rssi_value = 8'h5A;
        node_address = 8'h42;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        t_fixed();
        t_variable();
        t_address();
        t_checksum();
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
